// ==== logic/amo_pkg.sv ====
package amo_pkg;

  // wishbone byte addresses
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_CONF = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_DATA = 8'h0c;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADR_IRQ_EN = 8'h18;

  // mode register fields
  localparam int MODE_OPM_LSB = 21;
  localparam int MODE_OPM_W = 3;
  localparam int MODE_APPEND = 20;
  localparam int MODE_RSVD = 14;
  localparam int MODE_PAR = 13;
  localparam int MODE_DIV = 12;
  localparam int MODE_ZL = 11;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_WMASK = 32'h00f0_7800;

  // operating modes
  localparam logic [2:0] OPM_CONT = 3'h0;
  localparam logic [2:0] OPM_SINGLE = 3'h1;
  localparam logic [2:0] OPM_IDLE = 3'h2;

  // configuration register: channel enables
  localparam int CONF_CHEN_LSB = 8;
  localparam int NUM_CHAN = 4;
  localparam logic [31:0] CONF_RST = 32'h0000_0100;
  localparam logic [31:0] CONF_WMASK = 32'h0000_0f00;

  // status byte fields
  localparam int STAT_RDYN = 7;
  localparam int STAT_ERR = 6;
  localparam int STAT_PAR = 4;
  localparam int STAT_CHAN_W = 3;

  // interrupt sources
  localparam int IRQ_RDY = 0;
  localparam int IRQ_RSVD = 1;
  localparam int IRQ_OVR = 2;
  localparam int IRQ_W = 3;

  // result width and conversion timing
  localparam int RES_W = 24;
  localparam logic [15:0] ODR_TICKS = 16'h0010;
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_SETTLE = 2'b01,
    ENG_RUN = 2'b10
  } amo_eng_t;

endpackage

// ==== logic/amo_conv_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface amo_conv_if;
  logic restart;
  logic single_mode;
  logic idle_mode;
  logic clk_div;
  logic zero_lat;
  logic result;
  logic settling;

  modport ctl (
    output restart, single_mode, idle_mode, clk_div, zero_lat,
    input result, settling
  );
  modport eng (
    input restart, single_mode, idle_mode, clk_div, zero_lat,
    output result, settling
  );
endinterface
`default_nettype wire

// ==== logic/amo_conv.sv ====
`timescale 1ns/100ps
`default_nettype none
module amo_conv (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control from register side
  amo_conv_if.eng cv
);

  amo_pkg::amo_eng_t state;
  amo_pkg::amo_eng_t next_state;
  logic div_ph;
  logic next_div_ph;
  logic [15:0] mod_cnt;
  logic [15:0] next_mod_cnt;
  logic [2:0] settle_cnt;
  logic [2:0] next_settle_cnt;
  logic tick;
  logic conv_end;
  logic result;

  always_comb begin
    next_div_ph = ~div_ph;
    // with clk_div set the master clock is halved: only every second edge advances timing
    tick = ~cv.clk_div | div_ph;
    conv_end = tick && (mod_cnt == amo_pkg::ODR_TICKS - 16'h0001);
    next_mod_cnt = mod_cnt;
    if (tick) begin
      next_mod_cnt = conv_end ? 16'h0000 : mod_cnt + 16'h0001;
    end
    next_state = state;
    next_settle_cnt = settle_cnt;
    result = 1'b0;
    if (cv.restart) begin
      // reconfiguration restarts the filter from scratch
      next_state = cv.idle_mode ? amo_pkg::ENG_IDLE : amo_pkg::ENG_SETTLE;
      next_settle_cnt = 3'h0;
      next_mod_cnt = 16'h0000;
      next_div_ph = 1'b0;
    end else begin
      unique case (state)
        amo_pkg::ENG_IDLE: begin
          next_mod_cnt = 16'h0000;
        end
        amo_pkg::ENG_SETTLE: begin
          if (conv_end) begin
            if (settle_cnt == amo_pkg::SETTLE_CYCLES - 3'h1) begin
              // first valid result only after full settling
              result = 1'b1;
              next_settle_cnt = 3'h0;
              if (cv.single_mode) begin
                next_state = amo_pkg::ENG_IDLE;
              end else if (cv.zero_lat) begin
                // every result is a fully settled one
                next_state = amo_pkg::ENG_SETTLE;
              end else begin
                next_state = amo_pkg::ENG_RUN;
              end
            end else begin
              next_settle_cnt = settle_cnt + 3'h1;
            end
          end
        end
        amo_pkg::ENG_RUN: begin
          // later results follow at the output data rate
          result = conv_end;
          if (cv.zero_lat) begin
            next_state = amo_pkg::ENG_SETTLE;
            next_settle_cnt = 3'h0;
          end
        end
        default: begin
          next_state = amo_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= amo_pkg::ENG_SETTLE;
      div_ph <= 1'b0;
      mod_cnt <= 16'h0000;
      settle_cnt <= 3'h0;
    end else begin
      state <= next_state;
      div_ph <= next_div_ph;
      mod_cnt <= next_mod_cnt;
      settle_cnt <= next_settle_cnt;
    end
  end

  assign cv.result = result;
  assign cv.settling = (state == amo_pkg::ENG_SETTLE);

endmodule
`default_nettype wire

// ==== logic/amo_mode_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module amo_mode_ctrl (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // wishbone slave
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  // filtered samples from the modulator path
  input wire logic [23:0] SAMPLE_I,
  // interrupt
  output logic IRQ_O
);

  amo_conv_if cv ();

  logic [31:0] mode;
  logic [31:0] next_mode;
  logic [31:0] conf;
  logic [31:0] next_conf;
  logic [amo_pkg::IRQ_W-1:0] irq_stat;
  logic [amo_pkg::IRQ_W-1:0] next_irq_stat;
  logic [amo_pkg::IRQ_W-1:0] irq_en;
  logic [amo_pkg::IRQ_W-1:0] next_irq_en;
  logic [amo_pkg::RES_W-1:0] data;
  logic [amo_pkg::RES_W-1:0] next_data;
  logic [amo_pkg::STAT_CHAN_W-1:0] data_chan;
  logic [amo_pkg::STAT_CHAN_W-1:0] next_data_chan;
  logic rdy_n;
  logic next_rdy_n;
  logic ack;
  logic next_ack;
  logic [31:0] rd_data;
  logic [31:0] next_rd_data;
  logic restart;
  logic next_restart;

  logic [31:0] byte_mask;
  logic bus_req;
  logic wr_go;
  logic rd_data_go;
  logic [2:0] op_mode;
  logic [amo_pkg::NUM_CHAN-1:0] chan_en;
  logic [2:0] chan_cnt;
  logic [amo_pkg::STAT_CHAN_W-1:0] low_chan;
  logic zero_lat_eff;
  logic err;
  logic par;
  logic [7:0] stat_byte;
  logic [amo_pkg::IRQ_W-1:0] irq_evt;
  logic [amo_pkg::IRQ_W-1:0] irq_clr;

  // byte enables widened to a bit mask
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_sel
      assign byte_mask[8*gb +: 8] = {8{SEL_I[gb]}};
    end
  endgenerate

  // answer one cycle after the request; act on the edge ack is seen
  assign bus_req = CYC_I & STB_I;
  assign wr_go = bus_req & ack & WE_I;
  assign rd_data_go = bus_req & ack & ~WE_I & (ADR_I == amo_pkg::ADR_DATA);

  assign op_mode = mode[amo_pkg::MODE_OPM_LSB +: amo_pkg::MODE_OPM_W];
  assign chan_en = conf[amo_pkg::CONF_CHEN_LSB +: amo_pkg::NUM_CHAN];

  always_comb begin
    chan_cnt = 3'h0;
    low_chan = '0;
    for (int i = amo_pkg::NUM_CHAN - 1; i >= 0; i--) begin
      chan_cnt = chan_cnt + {2'b00, chan_en[i]};
      if (chan_en[i]) begin
        low_chan = i[amo_pkg::STAT_CHAN_W-1:0];
      end
    end
  end

  // zero latency only counts for one channel in continuous mode
  assign zero_lat_eff = mode[amo_pkg::MODE_ZL] && (chan_cnt == 3'h1) &&
    (op_mode == amo_pkg::OPM_CONT);

  // a set reserved bit is flagged rather than silently accepted
  assign err = mode[amo_pkg::MODE_RSVD];

  // even parity over result and channel tag when enabled
  assign par = mode[amo_pkg::MODE_PAR] & (^data ^ ^data_chan);

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[amo_pkg::STAT_RDYN] = rdy_n;
    stat_byte[amo_pkg::STAT_ERR] = err;
    stat_byte[amo_pkg::STAT_PAR] = par;
    stat_byte[amo_pkg::STAT_CHAN_W-1:0] = data_chan;
  end

  // register writes and reconfiguration restart
  always_comb begin
    next_mode = mode;
    next_conf = conf;
    next_irq_en = irq_en;
    irq_clr = '0;
    next_restart = 1'b0;
    if (wr_go) begin
      unique case (ADR_I)
        amo_pkg::ADR_MODE: begin
          next_mode = (mode & ~(byte_mask & amo_pkg::MODE_WMASK)) |
            (DAT_I & byte_mask & amo_pkg::MODE_WMASK);
          next_restart = 1'b1;
        end
        amo_pkg::ADR_CONF: begin
          next_conf = (conf & ~(byte_mask & amo_pkg::CONF_WMASK)) |
            (DAT_I & byte_mask & amo_pkg::CONF_WMASK);
          next_restart = 1'b1;
        end
        amo_pkg::ADR_IRQ_CLR: begin
          irq_clr = DAT_I[amo_pkg::IRQ_W-1:0] &
            {amo_pkg::IRQ_W{SEL_I[0]}};
        end
        amo_pkg::ADR_IRQ_EN: begin
          if (SEL_I[0]) begin
            next_irq_en = DAT_I[amo_pkg::IRQ_W-1:0];
          end
        end
        default: begin
          next_mode = mode;
        end
      endcase
    end
  end

  // result capture; a fresh result wins over a read that clears ready
  always_comb begin
    next_data = data;
    next_data_chan = data_chan;
    next_rdy_n = rdy_n;
    irq_evt = '0;
    if (rd_data_go) begin
      next_rdy_n = 1'b1;
    end
    if (cv.result) begin
      next_data = SAMPLE_I;
      next_data_chan = low_chan;
      next_rdy_n = 1'b0;
      irq_evt[amo_pkg::IRQ_RDY] = 1'b1;
      irq_evt[amo_pkg::IRQ_OVR] = ~rdy_n & ~rd_data_go;
    end
    if (restart) begin
      // old result is stale after reconfiguration
      next_rdy_n = 1'b1;
    end
    irq_evt[amo_pkg::IRQ_RSVD] = wr_go && (ADR_I == amo_pkg::ADR_MODE) &&
      SEL_I[1] && DAT_I[amo_pkg::MODE_RSVD];
  end

  // sticky status: set wins over clear
  assign next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;

  // read mux, registered together with ack
  always_comb begin
    next_ack = bus_req & ~ack;
    next_rd_data = 32'h0000_0000;
    if (bus_req & ~ack & ~WE_I) begin
      unique case (ADR_I)
        amo_pkg::ADR_MODE: begin
          next_rd_data = mode;
        end
        amo_pkg::ADR_CONF: begin
          next_rd_data = conf;
        end
        amo_pkg::ADR_STAT: begin
          next_rd_data = {24'h00_0000, stat_byte};
        end
        amo_pkg::ADR_DATA: begin
          if (mode[amo_pkg::MODE_APPEND]) begin
            next_rd_data = {data, stat_byte};
          end else begin
            // parity still travels in the status register
            next_rd_data = {8'h00, data};
          end
        end
        amo_pkg::ADR_IRQ_STAT: begin
          next_rd_data = {{(32 - amo_pkg::IRQ_W){1'b0}}, irq_stat};
        end
        amo_pkg::ADR_IRQ_EN: begin
          next_rd_data = {{(32 - amo_pkg::IRQ_W){1'b0}}, irq_en};
        end
        default: begin
          // unmapped and write-only words read as zero
          next_rd_data = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      mode <= amo_pkg::MODE_RST;
      conf <= amo_pkg::CONF_RST;
      irq_stat <= '0;
      irq_en <= '0;
      data <= '0;
      data_chan <= '0;
      rdy_n <= 1'b1;
      ack <= 1'b0;
      rd_data <= 32'h0000_0000;
      restart <= 1'b0;
    end else begin
      mode <= next_mode;
      conf <= next_conf;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      data <= next_data;
      data_chan <= next_data_chan;
      rdy_n <= next_rdy_n;
      ack <= next_ack;
      rd_data <= next_rd_data;
      restart <= next_restart;
    end
  end

  // engine control
  assign cv.restart = restart;
  assign cv.single_mode = (op_mode == amo_pkg::OPM_SINGLE);
  assign cv.idle_mode = (op_mode != amo_pkg::OPM_CONT) &&
    (op_mode != amo_pkg::OPM_SINGLE);
  assign cv.clk_div = mode[amo_pkg::MODE_DIV];
  assign cv.zero_lat = zero_lat_eff;

  amo_conv u_conv (
    .clk(REF_CLK_I),
    .rst(RST_I),
    .cv(cv)
  );

  assign ACK_O = ack;
  assign DAT_O = rd_data;
  assign IRQ_O = |(irq_stat & irq_en);

endmodule
`default_nettype wire

// ==== dv/amo_mode_ctrl_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module amo_mode_ctrl_asserts (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // bus
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O
);
  logic [31:0] mode;
  logic [7:0] since;
  logic [31:0] bm;
  logic wr_m;
  logic rd_st;
  logic rd_dt;
  assign bm = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  assign wr_m = ACK_O && WE_I && ADR_I == amo_pkg::ADR_MODE;
  assign rd_st = ACK_O && !WE_I && ADR_I == amo_pkg::ADR_STAT;
  assign rd_dt = ACK_O && !WE_I && ADR_I == amo_pkg::ADR_DATA;
  // shadow mode and cycles since restart, saturating
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      mode <= 32'h0;
      since <= 8'h0;
    end else begin
      if (wr_m) begin
        mode <= (mode & ~bm) | (DAT_I & bm);
      end
      if (wr_m || (ACK_O && WE_I && ADR_I == amo_pkg::ADR_CONF)) begin
        since <= 8'h0;
      end else if (since != 8'hff) begin
        since <= since + 8'h1;
      end
    end
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  property p_ack_pulse;
    CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one pulse");
  property p_dat_idle;
    !ACK_O |-> DAT_O == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data not idle");
  property p_settle;
    rd_st && !mode[12] && since < 8'h3c |-> DAT_O[7];
  endproperty
  a_settle: assert property (p_settle) else $error("early result");
  property p_div_settle;
    rd_st && mode[12] && since < 8'h78 |-> DAT_O[7];
  endproperty
  a_div_settle: assert property (p_div_settle) else $error("div early");
  property p_par_off;
    rd_st && !mode[13] |-> !DAT_O[4];
  endproperty
  a_par_off: assert property (p_par_off) else $error("parity shown");
  property p_par_on;
    rd_dt && mode[20] && mode[13] |-> DAT_O[4] == ^{DAT_O[31:8], DAT_O[2:0]};
  endproperty
  a_par_on: assert property (p_par_on) else $error("parity wrong");
  property p_append_off;
    rd_dt && !mode[20] |-> DAT_O[31:24] == 8'h0;
  endproperty
  a_append_off: assert property (p_append_off) else $error("append");
  property p_err_flag;
    rd_st |-> DAT_O[6] == mode[14];
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("err flag wrong");
endmodule
bind amo_mode_ctrl amo_mode_ctrl_asserts u_amo_mode_ctrl_asserts (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .ADR_I(ADR_I), .DAT_I(DAT_I),
  .DAT_O(DAT_O), .WE_I(WE_I), .SEL_I(SEL_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .ACK_O(ACK_O)
);
`default_nettype wire

// ==== dv/amo_smp_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// filter output stand-in: holds whatever value the bench sets
module amo_smp_model (
  // clock
  input wire logic clk_i,
  // bench value in, sample out
  input wire logic [23:0] val_i,
  output logic [23:0] sample_o
);
  always_ff @(posedge clk_i) begin
    sample_o <= val_i;
  end
endmodule
`default_nettype wire

// ==== dv/amo_mode_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module adc_mode_options_upper_bits_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [3:0] bsel = 4'hf;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [23:0] val = 24'h0;
  logic [23:0] smp;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic [23:0] rng = 24'h36;
  logic [31:0] q;
  logic [31:0] md;
  logic pe;
  logic ap;
  int err_total = 0;
  int check_count = 0;
  int cyc_n = 0;
  int t0;
  int dt;
  int lat;
  logic [31:0] cmode [5] = '{32'h0, 32'h800, 32'h800, 32'h1000, 32'h200800};
  logic [31:0] cconf [5] = '{32'h100, 32'h100, 32'h300, 32'h100, 32'h100};
  int cper [5] = '{32'h10, 32'h40, 32'h10, 32'h20, 32'h0};
  amo_smp_model u_amo_smp_model (.clk_i(clk), .val_i(val), .sample_o(smp));
  amo_mode_ctrl u_amo_mode_ctrl (
    .REF_CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(wdat), .DAT_O(rdat),
    .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
    .SAMPLE_I(smp), .IRQ_O(irq)
  );
  task automatic tally_and_finish;
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // entered just after an edge; leaves one idle cycle behind it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(32'(n < 20), 32'h1);
    @(posedge clk);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask
  // bench random source: 24-bit shift register with feedback taps
  function automatic logic [23:0] lfsr_next(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction
  function automatic logic [31:0] exp_data(input logic [23:0] v);
    logic [7:0] st;
    st = {3'h0, pe & ^v, 4'h0};
    return ap ? {v, st} : {8'h0, v};
  endfunction
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, amo_pkg::ADR_MODE, 32'h0);
    chk(q, amo_pkg::MODE_RST);
    bus(1'b0, amo_pkg::ADR_CONF, 32'h0);
    chk(q, amo_pkg::CONF_RST);
    bus(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0);
    // deliberate reserved-bit write to see it flagged
    bus(1'b1, amo_pkg::ADR_MODE, 32'h4000);
    bus(1'b0, amo_pkg::ADR_STAT, 32'h0);
    chk(32'(q[6]), 32'h1);
    bus(1'b0, amo_pkg::ADR_IRQ_STAT, 32'h0);
    chk(32'(q[1]), 32'h1);
    bsel = 4'hd;
    bus(1'b1, amo_pkg::ADR_MODE, 32'h0);
    bsel = 4'hf;
    bus(1'b0, amo_pkg::ADR_MODE, 32'h0);
    chk(q, 32'h4000);
    bus(1'b1, amo_pkg::ADR_IRQ_EN, 32'h1);
    for (int i = 0; i < 5; i++) begin
      rng = lfsr_next(rng);
      val <= rng;
      pe = rng[0];
      ap = rng[0] | rng[1];
      md = cmode[i] | {11'h0, ap, 6'h0, pe, 13'h0};
      lat = cmode[i][12] ? 32'h80 : 32'h40;
      bus(1'b1, amo_pkg::ADR_CONF, cconf[i]);
      bus(1'b1, amo_pkg::ADR_MODE, md);
      t0 = cyc_n;
      bus(1'b0, amo_pkg::ADR_STAT, 32'h0);
      chk(32'(q[7]), 32'h1);
      bus(1'b1, amo_pkg::ADR_IRQ_CLR, 32'h7);
      wait_irq();
      dt = cyc_n - t0;
      chk(32'(dt >= lat - 4 && dt <= lat + 4), 32'h1);
      t0 = cyc_n;
      bus(1'b1, amo_pkg::ADR_IRQ_CLR, 32'h7);
      wait_irq();
      dt = cyc_n - t0;
      chk(32'(cper[i] == 0 ? dt > 150 : dt >= cper[i] - 2 && dt <= cper[i] + 2),
          32'h1);
      bus(1'b0, amo_pkg::ADR_DATA, 32'h0);
      chk(q, exp_data(rng));
    end
    bus(1'b1, amo_pkg::ADR_IRQ_EN, 32'h0);
    bus(1'b1, amo_pkg::ADR_MODE, 32'h200000);
    repeat (80) @(posedge clk);
    chk(32'(irq), 32'h0);
    bus(1'b0, amo_pkg::ADR_IRQ_STAT, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, amo_pkg::ADR_IRQ_EN, 32'h1);
    chk(32'(irq), 32'h1);
    bus(1'b1, amo_pkg::ADR_IRQ_CLR, 32'h1);
    chk(32'(irq), 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
